// [core/srs_pkg.sv]
// Package for the software reset sequencer: register map, field layout,
// reset values and timing counts.
// Assumes a 50 MHz system clock and a 32-bit APB register bus.
package srs_pkg;

    localparam logic [15:0] SRS_CFG_LATCH_OFS = 16'hf108;
    localparam logic [15:0] SRS_CTRL_OFS      = 16'h0000;
    localparam logic [15:0] SRS_STAT_OFS      = 16'h0004;
    localparam logic [15:0] SRS_SWRST_OFS     = 16'h0008;

    localparam int          SRS_CTRL_BIDIR_BIT  = 0;
    localparam int          SRS_CTRL_RAMEN_BIT  = 1;
    localparam int          SRS_CTRL_RTCSEL_BIT = 2;

    localparam logic [15:0] SRS_SWRST_KEY     = 16'ha5c3;
    localparam logic [7:0]  SRS_LATCH_RST     = 8'h00;
    localparam logic [5:0]  SRS_FORCED_ONES   = 6'h3f;

    localparam int SRS_CLK_MHZ         = 50;
    localparam int SRS_SEQ_NS          = 1000;
    localparam int SRS_SEQ_CYC         = (SRS_SEQ_NS * SRS_CLK_MHZ) / 1000;
    localparam int SRS_FILT_NS         = 500;
    localparam int SRS_FILT_CYC        = (SRS_FILT_NS * SRS_CLK_MHZ) / 1000;

    typedef enum logic [1:0] {
        SRS_KIND_NONE  = 2'h0,
        SRS_KIND_SYNC  = 2'h1,
        SRS_KIND_ASYNC = 2'h2,
        SRS_KIND_SOFT  = 2'h3
    } srs_kind_t;

    typedef struct packed {
        logic        bidir;
        logic        ram_en;
        logic        rtc_on_lf;
    } srs_ctrl_t;

endpackage : srs_pkg

// [core/srs_sync2.sv]
// Two-flip-flop synchroniser for pin levels.
// Assumes inputs are asynchronous to CLOCK_I.
`timescale 1ns/1ps
module srs_sync2 #(
    parameter int           W       = 2,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // The reset value is a constant so the reset branch stays static.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_ff <= RST_VAL;
            q_ff    <= RST_VAL;
        end else begin
            meta_ff <= d_i;
            q_ff    <= meta_ff;
        end
    end

    assign q_o = q_ff;
endmodule : srs_sync2

// [core/srs_top.sv]
// Reset sequencer: software reset, start-up configuration latch and the
// choice between synchronous and asynchronous hardware reset.
// Assumes an APB master on CLOCK_I and an external reset network on the
// reset input pin, which is open-drain from this side.
//
// Summary of operation
// - A software reset instruction starts the reset sequence only while no reset is in progress and the reset and sense pins are not both low.
// - A software reset acts as a synchronous short reset but latches only config bits 12..8 and forces bits 7..2 to one.
// - A software reset stays synchronous whatever the sense pin shows, except while the reset pin is low too, when the asynchronous reset also asserts.
// - With bidirectional reset, a software reset pulls the reset pin low only while the sense pin is high.
// - Reset pin low with sense pin low gives an asynchronous hardware reset.
// - A short reset pulse gives a synchronous reset, a long one that lets sense fall gives an asynchronous reset.
// - The retained RAM stays unavailable until software sets the RAM enable bit.
// - In stand-by the real-time counter runs only on the low-frequency oscillator.
// - Sense falling during a hardware reset with the pin low switches at once to asynchronous reset.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module srs_top
    import srs_pkg::*;
(
    input  wire logic        CLOCK_I,
    input  wire logic        NRST_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [15:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        SW_RESET_INSTR_I,
    input  wire logic        RESET_IN_PIN_I,
    output logic             RESET_IN_PIN_O,
    output logic             RESET_IN_PIN_OE_O,
    input  wire logic        POWER_DOWN_SENSE_I,
    input  wire logic [15:0] CONFIG_PORT_PINS_I,
    input  wire logic        STANDBY_I,
    output logic             SYNC_RESET_O,
    output logic             ASYNC_RESET_O,
    output logic             RAM_ACCESS_O,
    output logic             RTC_RUN_O
);
    logic [1:0]  pins_s;
    logic        pin_low;
    logic        sense_low;
    logic [7:0]  seq_cnt_ff;
    logic [7:0]  filt_cnt_ff;
    srs_kind_t   kind_ff;
    srs_kind_t   nxt_kind;
    srs_ctrl_t   ctrl_ff;
    logic [7:0]  latch_ff;
    logic        seq_end;
    logic        apb_wr;
    logic        apb_rd;
    logic        sw_req;
    logic [16:0] misc_s;

    // Both pins reset to their idle high level so no false reset follows.
    srs_sync2 #(.W(2), .RST_VAL(2'h3)) u_sync (
        .clk_i  (CLOCK_I),
        .nrst_i (NRST_I),
        .d_i    ({RESET_IN_PIN_I, POWER_DOWN_SENSE_I}),
        .q_o    (pins_s)
    );

    // Configuration pins and the stand-by level come from outside as well.
    srs_sync2 #(.W(17), .RST_VAL(17'h00000)) u_sync_cfg (
        .clk_i  (CLOCK_I),
        .nrst_i (NRST_I),
        .d_i    ({STANDBY_I, CONFIG_PORT_PINS_I}),
        .q_o    (misc_s)
    );

    assign pin_low   = !pins_s[1];
    assign sense_low = !pins_s[0];

    assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
    assign apb_rd = PSEL_I && PENABLE_I && !PWRITE_I;
    // Software reset is accepted from the CPU strobe or a keyed write.
    assign sw_req = SW_RESET_INSTR_I || (apb_wr
                    && PADDR_I == SRS_SWRST_OFS
                    && PWDATA_I[15:0] == SRS_SWRST_KEY);

    // Low pin must outlast the filter window before it counts as reset.
    // The filter restarts during a sequence, so the tail of our own pull
    // on the pin cannot start a second reset once the sequence is over.
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            filt_cnt_ff <= 8'h00;
        end else if (!pin_low || kind_ff != SRS_KIND_NONE) begin
            filt_cnt_ff <= 8'h00;
        end else if (filt_cnt_ff < 8'(SRS_FILT_CYC)) begin
            filt_cnt_ff <= filt_cnt_ff + 8'h01;
        end
    end

    always_comb begin
        nxt_kind = kind_ff;
        if (pin_low && sense_low && kind_ff != SRS_KIND_SOFT) begin
            nxt_kind = SRS_KIND_ASYNC;
        end else if (sw_req && kind_ff == SRS_KIND_NONE) begin
            nxt_kind = SRS_KIND_SOFT;
        end else if (kind_ff == SRS_KIND_NONE && pin_low
                     && filt_cnt_ff == 8'(SRS_FILT_CYC)) begin
            nxt_kind = SRS_KIND_SYNC;
        end else if (seq_end) begin
            nxt_kind = SRS_KIND_NONE;
        end
    end

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            kind_ff <= SRS_KIND_NONE;
        end else begin
            kind_ff <= nxt_kind;
        end
    end

    // Sequence ends after a fixed count and once the pin has returned high.
    // A software reset ignores its own pin pull so it cannot hang itself.
    assign seq_end = (kind_ff != SRS_KIND_NONE)
                     && seq_cnt_ff == 8'(SRS_SEQ_CYC)
                     && (kind_ff == SRS_KIND_SOFT || !pin_low);

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            seq_cnt_ff <= 8'h00;
        end else if (kind_ff == SRS_KIND_NONE || nxt_kind != kind_ff) begin
            seq_cnt_ff <= 8'h00;
        end else if (seq_cnt_ff < 8'(SRS_SEQ_CYC)) begin
            seq_cnt_ff <= seq_cnt_ff + 8'h01;
        end
    end

    // Config latch holds pins 15..8; bits 7..2 of the port are forced one
    // after a software reset and kept in bits 9..4 of the status word.
    logic [5:0] low_cfg_ff;
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            latch_ff   <= SRS_LATCH_RST;
            low_cfg_ff <= 6'h00;
        end else if (seq_end && kind_ff == SRS_KIND_SOFT) begin
            latch_ff[4:0] <= misc_s[12:8];
            low_cfg_ff    <= SRS_FORCED_ONES;
        end else if (seq_end) begin
            latch_ff   <= misc_s[15:8];
            low_cfg_ff <= misc_s[7:2];
        end
    end

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ctrl_ff <= '0;
        end else if (apb_wr && PADDR_I == SRS_CTRL_OFS) begin
            ctrl_ff.bidir     <= PWDATA_I[SRS_CTRL_BIDIR_BIT];
            ctrl_ff.ram_en    <= PWDATA_I[SRS_CTRL_RAMEN_BIT];
            ctrl_ff.rtc_on_lf <= PWDATA_I[SRS_CTRL_RTCSEL_BIT];
        end else if (kind_ff == SRS_KIND_ASYNC) begin
            ctrl_ff.ram_en <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            PRDATA_O <= 32'h0000_0000;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            unique case (PADDR_I)
                SRS_CFG_LATCH_OFS: PRDATA_O <= {24'h0, latch_ff};
                SRS_CTRL_OFS:      PRDATA_O <= {29'h0, ctrl_ff.rtc_on_lf,
                                                ctrl_ff.ram_en,
                                                ctrl_ff.bidir};
                SRS_STAT_OFS:      PRDATA_O <= {22'h0, low_cfg_ff,
                                                pins_s, kind_ff};
                default:           PRDATA_O <= 32'h0000_0000;
            endcase
        end
    end

    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = apb_rd && PADDR_I != SRS_CFG_LATCH_OFS
                       && PADDR_I != SRS_CTRL_OFS && PADDR_I != SRS_STAT_OFS;

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            RESET_IN_PIN_OE_O <= 1'b0;
        end else begin
            RESET_IN_PIN_OE_O <= (nxt_kind == SRS_KIND_SOFT)
                                 && ctrl_ff.bidir && !sense_low;
        end
    end

    assign RESET_IN_PIN_O = 1'b0;
    assign SYNC_RESET_O   = (kind_ff == SRS_KIND_SYNC)
                            || (kind_ff == SRS_KIND_SOFT);
    assign ASYNC_RESET_O  = (kind_ff == SRS_KIND_ASYNC)
                            || (pin_low && sense_low);
    assign RAM_ACCESS_O   = ctrl_ff.ram_en && kind_ff == SRS_KIND_NONE;
    assign RTC_RUN_O      = !misc_s[16] || ctrl_ff.rtc_on_lf;

    async_on_low_a: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        pin_low && sense_low && kind_ff != SRS_KIND_SOFT
        |=> kind_ff == SRS_KIND_ASYNC)
        else $error("Pin and sense low did not give asynchronous reset.");
    soft_is_sync_a: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        kind_ff == SRS_KIND_SOFT |-> SYNC_RESET_O && !(ASYNC_RESET_O
        && !(pin_low && sense_low)))
        else $error("Software reset not synchronous.");
    soft_start_a: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        sw_req && kind_ff == SRS_KIND_NONE && !(pin_low && sense_low)
        |=> kind_ff == SRS_KIND_SOFT)
        else $error("Software reset request not taken.");
    pull_sense_a: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        RESET_IN_PIN_OE_O |-> $past(ctrl_ff.bidir) && !$past(sense_low))
        else $error("Reset pin pulled while sense low.");
    soft_latch_a: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        seq_end && kind_ff == SRS_KIND_SOFT
        |=> low_cfg_ff == SRS_FORCED_ONES
        && latch_ff[4:0] == $past(misc_s[12:8]))
        else $error("Software reset latch wrong.");
    ram_gate_a: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        RAM_ACCESS_O |-> ctrl_ff.ram_en && kind_ff == SRS_KIND_NONE)
        else $error("RAM accessible without enable.");
    rtc_stop_a: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        misc_s[16] && !ctrl_ff.rtc_on_lf |-> !RTC_RUN_O)
        else $error("Counter ran in stand-by on main oscillator.");
    short_sync_a: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        kind_ff == SRS_KIND_NONE && pin_low && !sense_low && !sw_req
        && filt_cnt_ff == 8'(SRS_FILT_CYC) |=> kind_ff == SRS_KIND_SYNC)
        else $error("Filtered pulse did not give synchronous reset.");
endmodule : srs_top

// [tb/srs_rst_net.sv]
// Model of the external reset network: open-drain reset pin and sense pin.
// Assumes one bench clock and a pull-up resistor on the reset pin.
`timescale 1ns/1ps
module srs_rst_net #(
    parameter int DISCH = 120
) (
    input  wire logic clk_i,
    input  wire logic ext_low_i,
    input  wire logic pwr_low_i,
    input  wire logic dut_oe_i,
    input  wire logic dut_lvl_i,
    output logic      pin_o,
    output logic      sense_o
);
    int unsigned low_cnt = 0;
    // Wired-OR to ground with a pull-up, so a released pin reads high.
    assign pin_o = !(ext_low_i || (dut_oe_i && !dut_lvl_i));
    always @(posedge clk_i) begin
        low_cnt <= pin_o ? 0 : low_cnt + 1;
    end
    // The sense capacitor drains only while the reset pin stays low.
    assign sense_o = !pwr_low_i && (low_cnt < DISCH);
endmodule : srs_rst_net

// [tb/srs_top_tb.sv]
// Self-checking bench for the reset sequencer, driven over APB.
// Assumes the reset network model sits on the reset and sense pins.
`timescale 1ns/1ps
module srs_top_tb;
    import srs_pkg::*;
    logic        clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, sw = 0;
    logic        ext_low = 0, pwr_low = 0, stby = 0, pin, sense;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwd = 32'h0, rd;
    logic        err;
    logic [15:0] cfg = 16'hb5a6;
    logic [31:0] PRDATA_O;
    logic        PREADY_O, PSLVERR_O, PIN_O, OE_O, SYNC_O, ASYNC_O, RAM_O, RTC_O;
    int          fails = 0, comparisons = 0, cycles = 0;
    always #10 clk = ~clk;
    srs_top dut (.CLOCK_I(clk), .NRST_I(nrst), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd),
        .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
        .SW_RESET_INSTR_I(sw), .RESET_IN_PIN_I(pin), .RESET_IN_PIN_O(PIN_O),
        .RESET_IN_PIN_OE_O(OE_O), .POWER_DOWN_SENSE_I(sense),
        .CONFIG_PORT_PINS_I(cfg), .STANDBY_I(stby), .SYNC_RESET_O(SYNC_O),
        .ASYNC_RESET_O(ASYNC_O), .RAM_ACCESS_O(RAM_O), .RTC_RUN_O(RTC_O));
    srs_rst_net net (.clk_i(clk), .ext_low_i(ext_low), .pwr_low_i(pwr_low),
        .dut_oe_i(OE_O), .dut_lvl_i(PIN_O), .pin_o(pin), .sense_o(sense));
    task automatic conclude();
        $display("checks %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            conclude();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Starts just after a rising edge, so back-to-back calls leave one idle
    // cycle and never assign psel twice in one time step.
    task automatic apb(input logic        w,
                       input logic [15:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (PREADY_O !== 1'b1);
        rd = PRDATA_O;
        err = PSLVERR_O;
        psel <= 0;
        pen <= 0;
    endtask : apb
    // Waits on one of the reset outputs, bounded so a stuck output shows up.
    task automatic waitsig(input int s, input logic v);
        logic g;
        for (int i = 0; i < 400; i++) begin
            @(negedge clk);
            g = (s == 0) ? SYNC_O : ASYNC_O;
            if (g === v) break;
        end
        chk("reset output", {31'h0, v}, {31'h0, g});
        @(posedge clk);
    endtask : waitsig
    task automatic pulse(input int n);
        ext_low <= 1;
        repeat (n) @(posedge clk);
    endtask : pulse
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        apb(0, SRS_CTRL_OFS, 32'h0); chk("ctrl", 32'h0, rd);
        apb(1, SRS_CFG_LATCH_OFS, 32'hff);
        apb(0, SRS_CFG_LATCH_OFS, 32'h0); chk("latch", {24'h0, SRS_LATCH_RST}, rd);
        apb(0, 16'h00f0, 32'h0); chk("unmapped", 32'h1, {31'h0, err});
        $display("test registers done");
        pulse(30); chk("sync", 32'h1, {31'h0, SYNC_O});
        // The kind field shows the reset in progress, so read it meanwhile.
        apb(0, SRS_STAT_OFS, 32'h0); chk("kind", 32'h1, {30'h0, rd[1:0]});
        ext_low <= 0;
        waitsig(0, 0);
        apb(0, SRS_STAT_OFS, 32'h0); chk("kind", 32'h0, {30'h0, rd[1:0]});
        chk("low cfg", {26'h0, cfg[7:2]}, {26'h0, rd[9:4]});
        apb(0, SRS_CFG_LATCH_OFS, 32'h0); chk("latch", {24'h0, cfg[15:8]}, rd);
        $display("test short pulse done");
        apb(1, SRS_CTRL_OFS, 32'h1);
        sw <= 1;
        @(posedge clk);
        sw <= 0;
        @(negedge clk); chk("pull low", 32'h1, {31'h0, OE_O});
        apb(0, SRS_STAT_OFS, 32'h0); chk("kind", 32'h3, {30'h0, rd[1:0]});
        waitsig(0, 0);
        apb(0, SRS_STAT_OFS, 32'h0);
        chk("forced", {26'h0, SRS_FORCED_ONES}, {26'h0, rd[9:4]});
        chk("kind", 32'h0, {30'h0, rd[1:0]});
        apb(0, SRS_CFG_LATCH_OFS, 32'h0);
        chk("latch", {27'h0, cfg[12:8]}, {27'h0, rd[4:0]});
        pwr_low <= 1;
        repeat (4) @(posedge clk);
        apb(1, SRS_SWRST_OFS, {16'h0, SRS_SWRST_KEY});
        @(negedge clk); chk("no pull", 32'h0, {31'h0, OE_O});
        chk("sync", 32'h1, {31'h0, SYNC_O});
        apb(0, SRS_STAT_OFS, 32'h0); chk("kind", 32'h3, {30'h0, rd[1:0]});
        waitsig(0, 0);
        pwr_low <= 0;
        $display("test software reset done");
        apb(1, SRS_CTRL_OFS, 32'h2);
        @(negedge clk); chk("ram", 32'h1, {31'h0, RAM_O});
        @(posedge clk);
        stby <= 1;
        // The stand-by level passes two flip-flops before it stops the count.
        repeat (3) @(negedge clk);
        chk("rtc", 32'h0, {31'h0, RTC_O});
        apb(1, SRS_CTRL_OFS, 32'h6);
        @(negedge clk); chk("rtc", 32'h1, {31'h0, RTC_O});
        @(posedge clk);
        stby <= 0;
        $display("test ram and rtc done");
        pulse(150); chk("async", 32'h1, {31'h0, ASYNC_O});
        apb(0, SRS_STAT_OFS, 32'h0); chk("kind", 32'h2, {30'h0, rd[1:0]});
        ext_low <= 0;
        waitsig(1, 0);
        apb(0, SRS_STAT_OFS, 32'h0); chk("kind", 32'h0, {30'h0, rd[1:0]});
        @(negedge clk); chk("ram", 32'h0, {31'h0, RAM_O});
        $display("test long pulse done");
        conclude();
    end
endmodule : srs_top_tb
